// ==== rtl/fsie_align_monitor.sv ====
// Tracks aligned forwarding: live flag, arming and sticky lost flag
module fsie_align_monitor (
  input  wire logic                    clk_sys_in, // System clock
  input  wire logic                    rst_in,     // Sync reset, high
  input  wire logic                    ce_in,      // Clock enable
  input  wire fsie_pkg::fsie_fwd_mode_e mode_in,   // Forwarding mode
  input  wire fsie_pkg::fsie_fwd_evt_s evt_in,     // Engine events
  input  wire logic                    clear_in,   // Read of status
  output logic                         live_out,   // Aligned now
  output logic                         lost_out    // Sticky lost flag
);

  fsie_pkg::fsie_mon_state_s cur_reg;
  fsie_pkg::fsie_mon_state_s cur_next;
  logic                      en;
  logic                      set_lost;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    en       = fsie_pkg::fwd_enabled(mode_in);
    set_lost = en && (cur_reg.st == fsie_pkg::MON_ARMED)
               && evt_in.loss;
    case (cur_reg.st)
      fsie_pkg::MON_OFF: begin
        if (en) begin
          cur_next.st = fsie_pkg::MON_WAIT;
        end
      end
      fsie_pkg::MON_WAIT: begin
        if (!en) begin
          cur_next.st = fsie_pkg::MON_OFF;
        end else if (evt_in.frame_done) begin
          cur_next.st = fsie_pkg::MON_ARMED;
        end
      end
      fsie_pkg::MON_ARMED: begin
        if (!en) begin
          cur_next.st = fsie_pkg::MON_OFF;
        end
      end
      default: begin
        cur_next.st = fsie_pkg::MON_OFF;
      end
    endcase
    // A loss in the cycle of the read survives to the next read
    cur_next.lost = (cur_reg.lost & ~clear_in) | set_lost;
    cur_next.live = en & evt_in.live;
    if (!ce_in) begin
      cur_next = cur_reg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cur_reg <= '{st: fsie_pkg::MON_OFF, live: 1'b0, lost: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign live_out = cur_reg.live;
  assign lost_out = cur_reg.lost;

  property p_lost_set;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && set_lost |=> lost_out;
  endproperty
  a_lost_set: assert property (p_lost_set)
    else $error("lost flag not set on armed loss");

  property p_lost_armed;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(lost_out) |-> $past(cur_reg.st) == fsie_pkg::MON_ARMED;
  endproperty
  a_lost_armed: assert property (p_lost_armed)
    else $error("lost flag set before a frame was sent");

  property p_live_off;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && mode_in == fsie_pkg::FSIE_FWD_OFF |=> !live_out;
  endproperty
  a_live_off: assert property (p_live_off)
    else $error("live flag high while forwarding off");

endmodule

// ==== rtl/fsie_forward_status_irq_enable.sv ====
// Forwarding status and interrupt enable register bank with irq output
//
// Added by the designer: the strobed register port.
module fsie_forward_status_irq_enable (
  input  wire logic                          clk_sys_in,      // Clock
  input  wire logic                          rst_in,          // Sync reset
  input  wire logic                          ce_in,           // Clock enable
  input  wire logic [fsie_pkg::ADDR_W-1:0]   addr_in,         // Reg address
  input  wire logic [fsie_pkg::DATA_W-1:0]   wr_data_in,      // Write data
  input  wire logic                          wr_en_in,        // Write strobe
  input  wire logic                          rd_en_in,        // Read strobe
  input  wire logic                          sync_live_in,    // Engine aligned
  input  wire logic                          frame_sent_in,   // Frame sent
  input  wire logic                          sync_loss_in,    // Loss seen
  input  wire logic [fsie_pkg::NUM_RX-1:0]   rx_irq_event_in, // Port events
  input  wire logic [fsie_pkg::NUM_RX-1:0]   rx_sts_read_in,  // Port sts read
  input  wire logic                          tx_irq_event_in, // Output event
  input  wire logic                          tx_sts_read_in,  // Output sts rd
  output logic [fsie_pkg::DATA_W-1:0]        rd_data_out,     // Read data
  output logic                               irq_out,         // Interrupt
  output logic [1:0]                         fwd_mode_out     // Mode to engine
);

  // ----------------------------------------------------------------------
  // State and wires
  // ----------------------------------------------------------------------
  localparam int EVT_ALL = fsie_pkg::NUM_RX + 1;

  fsie_pkg::fsie_top_state_s st_reg;
  fsie_pkg::fsie_top_state_s st_next;
  fsie_pkg::fsie_fwd_evt_s   fwd_evt;
  logic                      live_raw;
  logic                      lost_flag;
  logic                      live_eff;
  logic                      sts_clear;
  logic                      int_pend;
  logic                      evt_hit;
  logic [EVT_ALL-1:0]        src_sts;
  logic [EVT_ALL-1:0]        src_en;
  logic [fsie_pkg::EVT_W-1:0] evt_set;
  logic [fsie_pkg::DATA_W-1:0] rd_mux;

  // ----------------------------------------------------------------------
  // Alignment monitor
  // ----------------------------------------------------------------------
  assign fwd_evt.live       = sync_live_in;
  assign fwd_evt.frame_done = frame_sent_in;
  assign fwd_evt.loss       = sync_loss_in;

  // The read strobe itself clears; the flag seen by that read is the old one
  assign sts_clear = ce_in && rd_en_in
                     && fsie_pkg::hit(addr_in, fsie_pkg::OFS_FWD_STAT);

  fsie_align_monitor u_mon (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .mode_in    (st_reg.mode),
    .evt_in     (fwd_evt),
    .clear_in   (sts_clear),
    .live_out   (live_raw),
    .lost_out   (lost_flag)
  );

  // Masked by the current mode so a fresh disable reads zero at once
  assign live_eff = live_raw & fsie_pkg::fwd_enabled(st_reg.mode);

  // ----------------------------------------------------------------------
  // Pending and irq terms
  // ----------------------------------------------------------------------
  assign src_sts  = {st_reg.tx_pend, st_reg.rx_pend};
  assign src_en   = {st_reg.tx_en, st_reg.rx_en};
  assign int_pend = |(src_sts & src_en);
  assign evt_hit  = |(st_reg.evt_sts & st_reg.evt_mask);

  assign evt_set[fsie_pkg::EVT_LOST_BIT] = lost_flag & ~st_reg.lost_q;
  assign evt_set[fsie_pkg::EVT_ACQ_BIT]  = live_eff & ~st_reg.live_q;

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (addr_in)
      fsie_pkg::OFS_FWD_CTL: begin
        rd_mux[fsie_pkg::MODE_LSB +: 2] = st_reg.mode;
      end
      fsie_pkg::OFS_FWD_STAT: begin
        rd_mux[fsie_pkg::LIVE_BIT] = live_eff;
        rd_mux[fsie_pkg::LOST_BIT] = lost_flag;
      end
      fsie_pkg::OFS_IRQ_CTL: begin
        rd_mux[fsie_pkg::GLB_EN_BIT] = st_reg.glb_en;
        rd_mux[fsie_pkg::TX_EN_BIT]  = st_reg.tx_en;
        rd_mux[fsie_pkg::RX_EN_LSB +: fsie_pkg::NUM_RX] = st_reg.rx_en;
      end
      fsie_pkg::OFS_IRQ_STS: begin
        rd_mux[fsie_pkg::PEND_BIT]  = int_pend;
        rd_mux[fsie_pkg::TX_EN_BIT] = st_reg.tx_pend;
        rd_mux[fsie_pkg::RX_EN_LSB +: fsie_pkg::NUM_RX] = st_reg.rx_pend;
      end
      fsie_pkg::OFS_EVT_STS: begin
        rd_mux[fsie_pkg::EVT_W-1:0] = st_reg.evt_sts;
      end
      fsie_pkg::OFS_EVT_MASK: begin
        rd_mux[fsie_pkg::EVT_W-1:0] = st_reg.evt_mask;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Read data stands only in the cycle after the strobe
    st_next.rd_data = rd_en_in ? rd_mux : '0;
    if (wr_en_in) begin
      case (addr_in)
        fsie_pkg::OFS_FWD_CTL: begin
          st_next.mode = fsie_pkg::fsie_fwd_mode_e'(
            wr_data_in[fsie_pkg::MODE_LSB +: 2]);
        end
        fsie_pkg::OFS_IRQ_CTL: begin
          // Bits 6:5 are not stored, so they always read zero
          st_next.glb_en = wr_data_in[fsie_pkg::GLB_EN_BIT];
          st_next.tx_en  = wr_data_in[fsie_pkg::TX_EN_BIT];
          st_next.rx_en  =
            wr_data_in[fsie_pkg::RX_EN_LSB +: fsie_pkg::NUM_RX];
        end
        fsie_pkg::OFS_EVT_MASK: begin
          st_next.evt_mask = wr_data_in[fsie_pkg::EVT_W-1:0];
        end
        default: begin
          st_next.mode = st_reg.mode;
        end
      endcase
    end
    // Set wins over the clear in the same cycle
    st_next.rx_pend = (st_reg.rx_pend & ~rx_sts_read_in)
                      | rx_irq_event_in;
    st_next.tx_pend = (st_reg.tx_pend & ~tx_sts_read_in) | tx_irq_event_in;
    if (wr_en_in && fsie_pkg::hit(addr_in, fsie_pkg::OFS_EVT_STS)) begin
      st_next.evt_sts = (st_reg.evt_sts & ~wr_data_in[fsie_pkg::EVT_W-1:0])
                        | evt_set;
    end else begin
      st_next.evt_sts = st_reg.evt_sts | evt_set;
    end
    st_next.live_q = live_eff;
    st_next.lost_q = lost_flag;
    st_next.irq    = (st_reg.glb_en & int_pend) | evt_hit;
    if (!ce_in) begin
      st_next = st_reg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '{
        mode:     fsie_pkg::FSIE_FWD_OFF,
        glb_en:   1'b0,
        tx_en:    1'b0,
        rx_en:    '0,
        rx_pend:  '0,
        tx_pend:  1'b0,
        evt_sts:  '0,
        evt_mask: fsie_pkg::EVT_MASK_RST,
        live_q:   1'b0,
        lost_q:   1'b0,
        rd_data:  '0,
        irq:      1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out  = st_reg.rd_data;
  assign irq_out      = st_reg.irq;
  assign fwd_mode_out = st_reg.mode;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_rd_lost;
    @(posedge clk_sys_in) disable iff (rst_in)
    sts_clear |=> rd_data_out[fsie_pkg::LOST_BIT] == $past(lost_flag);
  endproperty
  a_rd_lost: assert property (p_rd_lost)
    else $error("status read lost the failure flag");

  property p_clear_on_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    sts_clear && !sync_loss_in |=> !lost_flag;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("failure flag not cleared by read");

  property p_live_follow;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && sync_live_in && st_reg.mode != fsie_pkg::FSIE_FWD_OFF
      ##1 ce_in && rd_en_in && addr_in == fsie_pkg::OFS_FWD_STAT
      && st_reg.mode != fsie_pkg::FSIE_FWD_OFF
      |=> rd_data_out[fsie_pkg::LIVE_BIT];
  endproperty
  a_live_follow: assert property (p_live_follow)
    else $error("live flag not reported while aligned");

  property p_irq_gate;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && !st_reg.glb_en && !evt_hit |=> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq raised with global enable low");

  property p_ie_write;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && wr_en_in && addr_in == fsie_pkg::OFS_IRQ_CTL
      |=> st_reg.tx_en == $past(wr_data_in[fsie_pkg::TX_EN_BIT])
      && st_reg.rx_en == $past(wr_data_in[3:0]);
  endproperty
  a_ie_write: assert property (p_ie_write)
    else $error("irq enable write not stored");

  property p_mode_write;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && wr_en_in && addr_in == fsie_pkg::OFS_FWD_CTL
      |=> fwd_mode_out == $past(wr_data_in[3:2]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode field not stored");

  property p_pend_bit;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rd_en_in && addr_in == fsie_pkg::OFS_IRQ_STS
      |=> rd_data_out[fsie_pkg::PEND_BIT]
          == $past(|({st_reg.tx_pend, st_reg.rx_pend}
                     & {st_reg.tx_en, st_reg.rx_en}));
  endproperty
  a_pend_bit: assert property (p_pend_bit)
    else $error("pending bit wrong");

  property p_rx_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rx_sts_read_in[0] && !rx_irq_event_in[0]
      |=> !st_reg.rx_pend[0];
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("port pending not cleared by status read");

  property p_reserved;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rd_en_in && addr_in == fsie_pkg::OFS_IRQ_CTL
      |=> rd_data_out[6:5] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved enable bits not zero");

  property p_rd_only_after;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && !rd_en_in |=> rd_data_out == '0;
  endproperty
  a_rd_only_after: assert property (p_rd_only_after)
    else $error("read data outside the answer cycle");

  property p_irq_on;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && st_reg.glb_en && int_pend |=> irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("irq not raised for enabled pending source");

  property p_irq_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && !int_pend && !evt_hit |=> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("irq raised with nothing pending");

  property p_ie_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    !(ce_in && wr_en_in && addr_in == fsie_pkg::OFS_IRQ_CTL)
      |=> $stable(st_reg.rx_en) && $stable(st_reg.tx_en)
      && $stable(st_reg.glb_en);
  endproperty
  a_ie_hold: assert property (p_ie_hold)
    else $error("irq enables changed without a write");

  property p_mode_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    !(ce_in && wr_en_in && addr_in == fsie_pkg::OFS_FWD_CTL)
      |=> $stable(fwd_mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed without a write");

  property p_live_rd;
    @(posedge clk_sys_in) disable iff (rst_in)
    sts_clear |=> rd_data_out[fsie_pkg::LIVE_BIT] == $past(live_eff);
  endproperty
  a_live_rd: assert property (p_live_rd)
    else $error("status read lost the live flag");

  property p_live_off_rd;
    @(posedge clk_sys_in) disable iff (rst_in)
    sts_clear && st_reg.mode == fsie_pkg::FSIE_FWD_OFF
      |=> !rd_data_out[fsie_pkg::LIVE_BIT];
  endproperty
  a_live_off_rd: assert property (p_live_off_rd)
    else $error("live flag read high while forwarding off");

  property p_sts_reserved;
    @(posedge clk_sys_in) disable iff (rst_in)
    sts_clear |=> rd_data_out[7:3] == 5'h00 && !rd_data_out[1];
  endproperty
  a_sts_reserved: assert property (p_sts_reserved)
    else $error("reserved status bits not zero");

  property p_ctl_reserved;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rd_en_in && addr_in == fsie_pkg::OFS_FWD_CTL
      |=> rd_data_out[7:4] == 4'h0 && rd_data_out[1:0] == 2'h0;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved)
    else $error("reserved mode register bits not zero");

  property p_rx_set;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rx_irq_event_in[1] |=> st_reg.rx_pend[1];
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("port event lost against its status read");

  property p_tx_set;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && tx_irq_event_in |=> st_reg.tx_pend;
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("output event not recorded");

  property p_tx_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && tx_sts_read_in && !tx_irq_event_in |=> !st_reg.tx_pend;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("output pending not cleared by status read");

endmodule

// ==== rtl/fsie_pkg.sv ====
// Constants, types and helpers for the forwarding status and irq enable bank
// Contract
// - Armed loss of alignment sets sticky lost flag
// - Lost flag needs one aligned frame first
// - Status read returns lost flag, then clears
// - Live flag follows engine alignment ability
// - Live flag reads zero when forwarding off
// - Global enable gates pending irqs onto output
// - Output port irq enable, reset zero
// - Four receive port irq enables, reset zero
// - Two-bit aligned forwarding mode select field
// - Pending bit ignores global enable, uses enables
// - Port pending clears on its status read
package fsie_pkg;

  // ----------------------------------------------------------------------
  // Register map and bus widths
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 8;
  localparam int          NUM_RX       = 4;
  localparam int          EVT_W        = 2;
  localparam logic [7:0]  OFS_FWD_CTL  = 8'h21;
  localparam logic [7:0]  OFS_FWD_STAT = 8'h22;
  localparam logic [7:0]  OFS_IRQ_CTL  = 8'h23;
  localparam logic [7:0]  OFS_IRQ_STS  = 8'h24;
  localparam logic [7:0]  OFS_EVT_STS  = 8'h28;
  localparam logic [7:0]  OFS_EVT_MASK = 8'h29;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          MODE_LSB     = 2;
  localparam int          LIVE_BIT     = 0;
  localparam int          LOST_BIT     = 2;
  localparam int          RX_EN_LSB    = 0;
  localparam int          TX_EN_BIT    = 4;
  localparam int          GLB_EN_BIT   = 7;
  localparam int          PEND_BIT     = 7;
  localparam int          EVT_LOST_BIT = 0;
  localparam int          EVT_ACQ_BIT  = 1;
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [1:0]  EVT_MASK_RST = 2'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSIE_FWD_OFF      = 2'b00,
    FSIE_FWD_BASIC    = 2'b01,
    FSIE_FWD_LINE_IL  = 2'b10,
    FSIE_FWD_LINE_CAT = 2'b11
  } fsie_fwd_mode_e;

  typedef enum logic [1:0] {
    MON_OFF   = 2'b00,
    MON_WAIT  = 2'b01,
    MON_ARMED = 2'b10
  } fsie_mon_st_e;

  typedef struct packed {
    logic live;
    logic frame_done;
    logic loss;
  } fsie_fwd_evt_s;

  typedef struct packed {
    fsie_mon_st_e st;
    logic         live;
    logic         lost;
  } fsie_mon_state_s;

  typedef struct packed {
    fsie_fwd_mode_e    mode;
    logic              glb_en;
    logic              tx_en;
    logic [NUM_RX-1:0] rx_en;
    logic [NUM_RX-1:0] rx_pend;
    logic              tx_pend;
    logic [EVT_W-1:0]  evt_sts;
    logic [EVT_W-1:0]  evt_mask;
    logic              live_q;
    logic              lost_q;
    logic [DATA_W-1:0] rd_data;
    logic              irq;
  } fsie_top_state_s;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic fwd_enabled(input fsie_fwd_mode_e m);
    return m != FSIE_FWD_OFF;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

endpackage

// ==== tb/fsie_forward_status_irq_enable_tb.sv ====
// Self-checking bench for the forwarding status and irq enable bank
module fsie_forward_status_irq_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       clk_sys_in;
  logic       rst_in;
  logic       ce_in;
  logic [7:0] addr_in;
  logic [7:0] wr_data_in;
  logic       wr_en_in;
  logic       rd_en_in;
  logic       sync_live_in;
  logic       frame_sent_in;
  logic       sync_loss_in;
  logic [3:0] rx_irq_event_in;
  logic [3:0] rx_sts_read_in;
  logic       tx_irq_event_in;
  logic       tx_sts_read_in;
  logic [7:0] rd_data_out;
  logic       irq_out;
  logic [1:0] fwd_mode_out;
  int         n_mismatch;
  int         checks_done;
  int         cycles;
  logic [7:0] bit_v;

  fsie_forward_status_irq_enable dut (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .ce_in           (ce_in),
    .addr_in         (addr_in),
    .wr_data_in      (wr_data_in),
    .wr_en_in        (wr_en_in),
    .rd_en_in        (rd_en_in),
    .sync_live_in    (sync_live_in),
    .frame_sent_in   (frame_sent_in),
    .sync_loss_in    (sync_loss_in),
    .rx_irq_event_in (rx_irq_event_in),
    .rx_sts_read_in  (rx_sts_read_in),
    .tx_irq_event_in (tx_irq_event_in),
    .tx_sts_read_in  (tx_sts_read_in),
    .rd_data_out     (rd_data_out),
    .irq_out         (irq_out),
    .fwd_mode_out    (fwd_mode_out)
  );

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // The whole sequence needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic cmp8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(input string nm, input logic e, input logic g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_in   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1;
    cmp8($sformatf("reg %h", a), e, rd_data_out);
  endtask

  task automatic pulse(input logic [3:0] rxe, input logic txe,
                       input logic [3:0] rxr, input logic txr,
                       input logic fs, input logic ls);
    @(posedge clk_sys_in);
    rx_irq_event_in <= rxe;
    tx_irq_event_in <= txe;
    rx_sts_read_in  <= rxr;
    tx_sts_read_in  <= txr;
    frame_sent_in   <= fs;
    sync_loss_in    <= ls;
    @(posedge clk_sys_in);
    rx_irq_event_in <= 4'h0;
    tx_irq_event_in <= 1'b0;
    rx_sts_read_in  <= 4'h0;
    tx_sts_read_in  <= 1'b0;
    frame_sent_in   <= 1'b0;
    sync_loss_in    <= 1'b0;
  endtask

  // Lets the registered irq output follow the state
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk_sys_in);
    #1;
    cmp1("irq_out", e, irq_out);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    {ce_in, wr_en_in, rd_en_in, sync_live_in} = 4'h1 << 3;
    {frame_sent_in, sync_loss_in, tx_irq_event_in, tx_sts_read_in} = 4'h0;
    {addr_in, wr_data_in, rx_irq_event_in, rx_sts_read_in} = 24'h0;
    {n_mismatch, checks_done, cycles} = '0;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h00);
    rd_chk(fsie_pkg::OFS_IRQ_CTL, 8'h00);
    rd_chk(8'h30, 8'h00);
    cmp1("irq_out", 1'b0, irq_out);
    $display("test reset done");

    wr(fsie_pkg::OFS_IRQ_CTL, 8'hff);
    rd_chk(fsie_pkg::OFS_IRQ_CTL, 8'h9f);
    for (int i = 0; i < 8; i++) begin
      wr(fsie_pkg::OFS_IRQ_CTL, 8'h01 << i);
      rd_chk(fsie_pkg::OFS_IRQ_CTL, (8'h01 << i) & 8'h9f);
    end
    wr(8'h30, 8'h55);
    ce_in <= 1'b0;
    wr(fsie_pkg::OFS_IRQ_CTL, 8'h11);
    ce_in <= 1'b1;
    rd_chk(fsie_pkg::OFS_IRQ_CTL, 8'h80);
    $display("test enables done");

    for (int m = 0; m < 4; m++) begin
      wr(fsie_pkg::OFS_FWD_CTL, 8'hf3 | (8'(m) << 2));
      rd_chk(fsie_pkg::OFS_FWD_CTL, 8'(m) << 2);
      cmp8("fwd_mode_out", 8'(m), {6'h00, fwd_mode_out});
    end
    $display("test mode done");

    wr(fsie_pkg::OFS_FWD_CTL, 8'h00);
    sync_live_in <= 1'b1;
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h00);
    wr(fsie_pkg::OFS_FWD_CTL, 8'h04);
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h01);
    sync_live_in <= 1'b0;
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h00);
    pulse(4'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1);
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h00);
    pulse(4'h0, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0);
    pulse(4'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1);
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h04);
    rd_chk(fsie_pkg::OFS_FWD_STAT, 8'h00);
    $display("test alignment done");

    for (int i = 0; i < 5; i++) begin
      bit_v = 8'h01 << i;
      wr(fsie_pkg::OFS_IRQ_CTL, 8'h00);
      pulse(bit_v[3:0], bit_v[4], 4'h0, 1'b0, 1'b0, 1'b0);
      rd_chk(fsie_pkg::OFS_IRQ_STS, bit_v);
      wr(fsie_pkg::OFS_IRQ_CTL, bit_v);
      rd_chk(fsie_pkg::OFS_IRQ_STS, 8'h80 | bit_v);
      irq_chk(1'b0);
      wr(fsie_pkg::OFS_IRQ_CTL, 8'h80 | bit_v);
      irq_chk(1'b1);
      pulse(4'h0, 1'b0, bit_v[3:0], bit_v[4], 1'b0, 1'b0);
      rd_chk(fsie_pkg::OFS_IRQ_STS, 8'h00);
      irq_chk(1'b0);
    end
    $display("test pending done");

    wr(fsie_pkg::OFS_IRQ_CTL, 8'h00);
    rd_chk(fsie_pkg::OFS_EVT_STS, 8'h03);
    wr(fsie_pkg::OFS_EVT_MASK, 8'h01);
    rd_chk(fsie_pkg::OFS_EVT_MASK, 8'h01);
    irq_chk(1'b1);
    wr(fsie_pkg::OFS_EVT_STS, 8'h01);
    irq_chk(1'b0);
    rd_chk(fsie_pkg::OFS_EVT_STS, 8'h02);
    wr(fsie_pkg::OFS_EVT_MASK, 8'h03);
    irq_chk(1'b1);
    wr(fsie_pkg::OFS_EVT_STS, 8'h02);
    rd_chk(fsie_pkg::OFS_EVT_STS, 8'h00);
    irq_chk(1'b0);
    $display("test events done");

    // A second reset in mid-run must restore the irq enable and mode registers
    wr(fsie_pkg::OFS_IRQ_CTL, 8'h9f);
    wr(fsie_pkg::OFS_FWD_CTL, 8'h0c);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_chk(fsie_pkg::OFS_IRQ_CTL, 8'h00);
    rd_chk(fsie_pkg::OFS_FWD_CTL, 8'h00);
    cmp8("fwd_mode_out", 8'h00, {6'h00, fwd_mode_out});
    $display("test second reset done");
    give_verdict();
  end
endmodule
